// File: bench/logic_math_chain_assertions.sv
/*
 * Port checker for the table selector and math chain.
 * Assumes the single clk domain and synchronous active-high rst.
 */
`timescale 1ns/1ps
module logic_math_chain_assertions (
   input wire logic                       clk,
   input wire logic                       rst,
   input wire logic_math_pkg::reg_req_t   req,
   input wire logic_math_pkg::sig_bus_t   sig_in,
   input wire logic_math_pkg::table_bus_t table_in,
   input wire logic [31:0]                rdata,
   input wire logic [15:0]                sel_value,
   input wire logic [1:0]                 sel_slot,
   input wire logic [15:0]                math_value
);
   logic [31:0]                ctrl_q;
   logic [31:0]                ctrl_p;
   logic_math_pkg::table_bus_t tab_p;
   logic [2:0]                 ref_idx;

   // shadow of the selector word, aligned with what each result used
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= '0;
         ctrl_p <= '0;
      end else begin
         if (req.wr && req.addr == logic_math_pkg::ADDR_SEL_CTRL) begin
            ctrl_q <= req.wdata;
         end
         ctrl_p <= ctrl_q;
      end
      tab_p <= table_in;
   end
   assign ref_idx = ctrl_p[logic_math_pkg::SEL_REF_POS
                           + logic_math_pkg::FIELD_STRIDE * sel_slot +: 3];

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_reset_clear;
      $fell(rst) |-> rdata == 32'h0000_0000 && sel_value == 16'h0000 && sel_slot == 2'h0;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear");
   property p_disabled_zero;
      !ctrl_q[0] |=> sel_value == 16'h0000 && sel_slot == 2'h0;
   endproperty
   a_disabled_zero: assert property (p_disabled_zero) else $error("disabled output");
   property p_sel_follows;
      ctrl_p[0] |-> sel_value == tab_p.value[ref_idx];
   endproperty
   a_sel_follows: assert property (p_sel_follows) else $error("wrong table");
   property p_slot_range;
      sel_slot != 2'h3;
   endproperty
   a_slot_range: assert property (p_slot_range) else $error("slot out of range");
   property p_stable;
      $stable(sig_in) && $stable(table_in) && !$past(req.wr)
         |=> $stable(sel_value) && $stable(sel_slot) && $stable(math_value);
   endproperty
   a_stable: assert property (p_stable) else $error("output moved");
   property p_rdata_idle;
      !req.rd |=> rdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero");
   property p_sel_stat;
      req.rd && req.addr == logic_math_pkg::ADDR_SEL_STAT
         |=> rdata[17:0] == {$past(sel_slot), $past(sel_value)};
   endproperty
   a_sel_stat: assert property (p_sel_stat) else $error("selector status");
   property p_math_stat;
      req.rd && req.addr == logic_math_pkg::ADDR_MATH_STAT |=> rdata[15:0] == $past(math_value);
   endproperty
   a_math_stat: assert property (p_math_stat) else $error("math status");
endmodule

bind logic_math_chain logic_math_chain_assertions i_chk (
   .clk(clk), .rst(rst), .req(req), .sig_in(sig_in), .table_in(table_in), .rdata(rdata),
   .sel_value(sel_value), .sel_slot(sel_slot), .math_value(math_value));

// File: bench/logic_math_chain_test.sv
/*
 * Self-checking bench: register writes set up selector and math chain.
 * Assumes one-cycle register port and fixed table values from signal_blocks.
 */
`timescale 1ns/1ps
module logic_math_chain_test;
   typedef struct packed {
      logic [3:0]  op;
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] e;
   } mcase_t;
   localparam mcase_t MC [17] = '{
      '{4'h0, 16'h0BB8, 16'h07D0, 16'h0000}, '{4'h1, 16'h0BB8, 16'h07D0, 16'h0064},
      '{4'h2, 16'h0BB8, 16'h07D0, 16'h0064}, '{4'h3, 16'h07D0, 16'h07D0, 16'h0064},
      '{4'h4, 16'h0BB8, 16'h07D0, 16'h0000}, '{4'h5, 16'h07D0, 16'h07D0, 16'h0064},
      '{4'h6, 16'h0096, 16'h0032, 16'h0064}, '{4'h7, 16'h0096, 16'h0032, 16'h0000},
      '{4'h8, 16'h0064, 16'h0032, 16'h0064}, '{4'h7, 16'h0064, 16'h0064, 16'h0064},
      '{4'h9, 16'h1F40, 16'h1388, 16'h2710}, '{4'hA, 16'h07D0, 16'h0BB8, 16'h0000},
      '{4'hB, 16'h1388, 16'h07D0, 16'h03E8}, '{4'hC, 16'h07D0, 16'h1388, 16'h0FA0},
      '{4'hC, 16'h07D0, 16'h0000, 16'h2710}, '{4'hD, 16'h0BB8, 16'h07D0, 16'h07D0},
      '{4'hE, 16'h0BB8, 16'h07D0, 16'h0BB8}};
   logic                        clk = 1'b0;
   logic                        rst = 1'b1;
   logic_math_pkg::reg_req_t    req = '0;
   logic_math_pkg::sig_bus_t    sig_set = '0;
   logic_math_pkg::sig_bus_t    sig_in;
   logic_math_pkg::table_bus_t  table_in;
   logic [31:0]                 rdata;
   logic [15:0]                 sel_value;
   logic [1:0]                  sel_slot;
   logic [15:0]                 math_value;
   logic [15:0]                 a_tab [3] = '{16'hFFFD, 16'h0005, 16'h0007};
   int                          n_mismatch = 0;
   int                          comparisons = 0;

   always #12.5 clk = ~clk;

   signal_blocks i_far (.clk(clk), .rst(rst), .sig_set(sig_set), .sig_in(sig_in),
                        .table_in(table_in));
   logic_math_chain i_dut (.clk(clk), .rst(rst), .req(req), .sig_in(sig_in),
      .table_in(table_in), .rdata(rdata), .sel_value(sel_value), .sel_slot(sel_slot),
      .math_value(math_value));

   function automatic logic [15:0] tbl(input int k);
      return 16'hA000 | 16'(k);
   endfunction
   function automatic logic cmp_f(input int op, input logic signed [15:0] a,
                                  input logic signed [15:0] b);
      case (op)
         0: return a == b;
         1: return a != b;
         2: return a > b;
         3: return a >= b;
         4: return a < b;
         default: return a <= b;
      endcase
   endfunction
   function automatic logic comb_f(input int c, input logic [2:0] t);
      case (c)
         0: return 1'b1;
         1: return &t;
         2: return |t;
         3: return (t[0] & t[1]) | t[2];
         default: return (t[0] | t[1]) & t[2];
      endcase
   endfunction

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp,
                         input logic [31:0] mask);
      @(posedge clk);
      req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      chk(name, exp & mask, rdata & mask);
   endtask
   // condition true as unused==unused, false as unused!=unused
   task automatic set_conds(input int s, input logic [2:0] t);
      for (int j = 0; j < 3; j++) begin
         wr(logic_math_pkg::ADDR_COND_BASE + 8'(12 * s + 4 * j),
            t[j] ? 32'h0000_0000 : 32'h0000_0100);
      end
   endtask
   task automatic settle;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end

   initial begin
      logic e;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      sig_set.value[0] <= 16'h0BB8;
      settle();
      chk("sel_value", 32'h0000_0000, sel_value);
      rd_chk("unmapped", 8'h60, 32'h0000_0000, 32'hFFFF_FFFF);
      rd_chk("misaligned", 8'h02, 32'h0000_0000, 32'hFFFF_FFFF);
      $display("test reset done");
      for (int c = 0; c < 5; c++) begin
         for (int t = 0; t < 8; t++) begin
            wr(logic_math_pkg::ADDR_SEL_CTRL, 32'h0000_7251 | (32'(c) << 16));
            set_conds(0, 3'(t));
            settle();
            e = comb_f(c, 3'(t));
            chk("sel_value", e ? tbl(5) : tbl(2), sel_value);
            chk("sel_slot", e ? 2'h0 : 2'h1, sel_slot);
         end
      end
      wr(logic_math_pkg::ADDR_SEL_CTRL, 32'h0002_7251);
      set_conds(0, 3'h1);
      for (int i = 0; i < 3; i++) begin
         for (int op = 0; op < 6; op++) begin
            sig_set.value[0] <= a_tab[i];
            sig_set.value[1] <= 16'h0005;
            wr(logic_math_pkg::ADDR_COND_BASE, 32'h0000_0021 | (32'(op) << 8));
            settle();
            e = cmp_f(op, a_tab[i], 16'h0005);
            chk("sel_value", e ? tbl(5) : tbl(2), sel_value);
         end
      end
      for (int s = 0; s < 3; s++) begin
         set_conds(s, 3'h0);
      end
      wr(logic_math_pkg::ADDR_SEL_CTRL, 32'h0111_7251);
      settle();
      chk("sel_value", tbl(5), sel_value);
      chk("sel_slot", 2'h0, sel_slot);
      wr(logic_math_pkg::ADDR_SEL_CTRL, 32'h0011_7251);
      settle();
      chk("sel_value", tbl(7), sel_value);
      wr(logic_math_pkg::ADDR_SEL_CTRL, 32'h0001_7251);
      settle();
      rd_chk("sel_stat", logic_math_pkg::ADDR_SEL_STAT, {16'h0001, tbl(2)}, 32'h0003_FFFF);
      wr(logic_math_pkg::ADDR_SEL_CTRL, 32'h0000_0000);
      settle();
      chk("sel_value", 32'h0000_0000, sel_value);
      $display("test selector done");
      for (int i = 0; i < 3; i++) begin
         wr(logic_math_pkg::ADDR_MIN_BASE + 8'(4 * i), 32'h4000_0000 | 32'(i + 1));
      end
      foreach (MC[i]) begin
         sig_set.value[0] <= MC[i].a;
         sig_set.value[1] <= MC[i].b;
         wr(logic_math_pkg::ADDR_MATH_CTRL, 32'h0020_0001 | (32'(MC[i].op) << 4));
         settle();
         chk("math_value", MC[i].e, math_value);
      end
      sig_set.value[0] <= 16'h0BB8;
      sig_set.value[1] <= 16'h07D0;
      sig_set.value[2] <= 16'h03E8;
      wr(logic_math_pkg::ADDR_MATH_CTRL, 32'h41AD_0A91);
      settle();
      chk("math_value", 32'h0000_07D0, math_value);
      sig_set.value[0] <= 16'h07D0;
      wr(logic_math_pkg::ADDR_RNG_BASE, 32'h0BB8_03E8);
      wr(logic_math_pkg::ADDR_MIN_BASE, 32'h2000_0001);
      wr(logic_math_pkg::ADDR_OUT_RANGE, 32'h012C_0064);
      wr(logic_math_pkg::ADDR_MATH_CTRL, 32'h0000_0091);
      settle();
      rd_chk("math_stat", logic_math_pkg::ADDR_MATH_STAT, 32'h09C4_0096,
             32'hFFFF_FFFF);
      $display("test math done");
      complete_run();
   end
endmodule

// File: bench/signal_blocks.sv
/*
 * Far-side model: the signal blocks and lookup tables feeding the block.
 * Assumes the bench sets the signal values; tables hold fixed outputs.
 */
`timescale 1ns/1ps
module signal_blocks (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic_math_pkg::sig_bus_t   sig_set,
   output logic_math_pkg::sig_bus_t        sig_in,
   output logic_math_pkg::table_bus_t      table_in
);
   // signal blocks refresh once per clock, like any other function block
   always_ff @(posedge clk) begin
      if (rst) begin
         sig_in <= '0;
      end else begin
         sig_in <= sig_set;
      end
   end

   // distinct table outputs so a wrong pick is always visible
   always_comb begin
      for (int k = 0; k < logic_math_pkg::NUM_TABLE; k++) begin
         table_in.value[k] = 16'hA000 | 16'(k);
      end
   end
endmodule

// File: design/logic_math_chain.sv
/*
 * Conditional lookup-table selector and four-stage math chain.
 * Assumes signal and table values arrive synchronous to clk, and a
 * register master that never issues read and write in the same cycle.
 */
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module logic_math_chain (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic_math_pkg::reg_req_t   req,
   input  wire logic_math_pkg::sig_bus_t   sig_in,
   input  wire logic_math_pkg::table_bus_t table_in,
   output logic [31:0]                 rdata,
   output logic [15:0]                 sel_value,
   output logic [1:0]                  sel_slot,
   output logic [15:0]                 math_value
);

   logic_math_pkg::state_t st;
   logic_math_pkg::state_t next_st;

   // signal source pick: 0 means unused and reads as zero
   function automatic logic signed [31:0] pick(input logic [3:0] src,
                                              input logic_math_pkg::sig_bus_t bus);
      logic signed [31:0] r;
      r = 32'sh0000_0000;
      if (src != 4'h0 && src <= 4'h8) begin
         r = 32'($signed(bus.value[src - 4'h1]));
      end
      return r;
   endfunction

   function automatic logic compare(input logic [3:0] op,
                                    input logic signed [31:0] a,
                                    input logic signed [31:0] b);
      logic r;
      r = 1'b0;
      case (op)
         4'h0: r = (a == b);
         4'h1: r = (a != b);
         4'h2: r = (a >  b);
         4'h3: r = (a >= b);
         4'h4: r = (a <  b);
         4'h5: r = (a <= b);
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic signed [31:0] sat(input logic signed [47:0] v);
      logic signed [31:0] r;
      r = 32'sh0000_0000;
      if (v > 48'(logic_math_pkg::PCT_FULL)) begin
         r = logic_math_pkg::PCT_FULL;
      end else if (v > 48'sh0) begin
         r = v[31:0];
      end
      return r;
   endfunction

   function automatic logic signed [31:0] norm(input logic signed [31:0] x,
                                               input logic signed [15:0] mn,
                                               input logic signed [15:0] mx);
      logic signed [47:0] num;
      logic signed [47:0] den;
      logic signed [31:0] r;
      num = 48'(x - 32'(mn)) * 48'(logic_math_pkg::PCT_FULL);
      den = 48'(mx) - 48'(mn);
      r = 32'sh0000_0000;
      // empty or inverted span gives zero rather than a divide fault
      if (den > 48'sh0) begin
         r = sat(num / den);
      end
      return r;
   endfunction

   function automatic logic signed [31:0] stage(input logic [3:0] op,
                                                input logic signed [31:0] a,
                                                input logic signed [31:0] b);
      logic signed [31:0] r;
      logic signed [47:0] wa;
      logic signed [47:0] wb;
      logic               ta;
      logic               tb;
      wa = 48'(a);
      wb = 48'(b);
      ta = (a >= logic_math_pkg::PCT_ONE);
      tb = (b >= logic_math_pkg::PCT_ONE);
      r = a;
      case (op)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5:
            r = compare(op, a, b) ? logic_math_pkg::PCT_ONE : 32'sh0;
         4'h6: r = (ta | tb) ? logic_math_pkg::PCT_ONE : 32'sh0;
         4'h7: r = (ta & tb) ? logic_math_pkg::PCT_ONE : 32'sh0;
         4'h8: r = (ta ^ tb) ? logic_math_pkg::PCT_ONE : 32'sh0;
         4'h9: r = sat(wa + wb);
         4'hA: r = sat(wa - wb);
         4'hB: r = sat((wa * wb) / 48'(logic_math_pkg::PCT_FULL));
         4'hC: begin
            if (b == 32'sh0) begin
               r = logic_math_pkg::PCT_FULL;
            end else begin
               r = sat((wa * 48'(logic_math_pkg::PCT_FULL)) / wb);
            end
         end
         4'hD: r = sat((a < b) ? wa : wb);
         4'hE: r = sat((a > b) ? wa : wb);
         default: r = a;  // undefined codes pass the first operand
      endcase
      return r;
   endfunction

   // selector evaluation
   logic [2:0]         slot_hit;
   logic [1:0]         win_slot;
   logic [15:0]        sel_calc;
   // math chain evaluation
   logic signed [31:0] min_pct [logic_math_pkg::NUM_MIN];
   logic signed [31:0] chain   [logic_math_pkg::NUM_STAGE+1];
   logic signed [47:0] out_calc;

   always_comb begin
      logic [2:0]         c;
      logic [3:0]         k;
      logic signed [31:0] wmul;
      logic signed [31:0] opb;
      c = 3'b000;
      k = 4'h0;
      wmul = 32'sh0;
      opb = 32'sh0;
      for (int s = 0; s < logic_math_pkg::NUM_SLOT; s++) begin
         for (int j = 0; j < 3; j++) begin
            k = 4'(s * 3 + j);
            c[j] = compare({1'b0, st.cfg.cond_op[k]},
                           pick(st.cfg.arg_a[k], sig_in),
                           pick(st.cfg.arg_b[k], sig_in));
         end
         case (st.cfg.comb[s])
            3'h0: slot_hit[s] = 1'b1;
            3'h1: slot_hit[s] = c[0] & c[1] & c[2];
            3'h2: slot_hit[s] = c[0] | c[1] | c[2];
            3'h3: slot_hit[s] = (c[0] & c[1]) | c[2];
            3'h4: slot_hit[s] = (c[0] | c[1]) & c[2];
            default: slot_hit[s] = 1'b0;
         endcase
      end
      if (slot_hit[0]) begin
         win_slot = 2'h0;
      end else if (slot_hit[1]) begin
         win_slot = 2'h1;
      end else if (slot_hit[2]) begin
         win_slot = 2'h2;
      end else begin
         win_slot = 2'h0;
      end
      sel_calc = table_in.value[st.cfg.table_ref[win_slot]];

      for (int i = 0; i < logic_math_pkg::NUM_MIN; i++) begin
         wmul = norm(pick(st.cfg.in_src[i], sig_in),
                     st.cfg.in_min[i], st.cfg.in_max[i]);
         // weight product stays well inside 48 bits
         min_pct[i] = 32'((48'(wmul) * 48'($signed(st.cfg.in_weight[i])))
                          >>> logic_math_pkg::WEIGHT_FRAC);
      end
      chain[0] = (st.cfg.first_src == 3'h0 || st.cfg.first_src > 3'h5) ?
                 32'sh0 : min_pct[st.cfg.first_src - 3'h1];
      for (int g = 0; g < logic_math_pkg::NUM_STAGE; g++) begin
         if (st.cfg.stage_b[g] == 3'h0 || st.cfg.stage_b[g] > 3'h5) begin
            chain[g+1] = chain[g];
         end else begin
            opb = min_pct[st.cfg.stage_b[g] - 3'h1];
            chain[g+1] = stage(st.cfg.stage_op[g], chain[g], opb);
         end
      end
      out_calc = 48'($signed(st.cfg.out_min))
               + (48'(chain[logic_math_pkg::NUM_STAGE])
                  * (48'($signed(st.cfg.out_max)) - 48'($signed(st.cfg.out_min))))
                 / 48'(logic_math_pkg::PCT_FULL);
   end

   // register port and result capture
   always_comb begin
      logic [7:0]  a;
      logic [31:0] d;
      logic [3:0]  idx;
      a = req.addr;
      d = req.wdata;
      idx = 4'h0;
      next_st = st;
      next_st.rdata = 32'h0000_0000;  // read data stand one cycle only

      if (req.wr) begin
         if (a == logic_math_pkg::ADDR_SEL_CTRL) begin
            next_st.cfg.sel_en = d[logic_math_pkg::SEL_EN_POS];
            for (int s = 0; s < logic_math_pkg::NUM_SLOT; s++) begin
               next_st.cfg.table_ref[s] =
                  d[logic_math_pkg::SEL_REF_POS + s*logic_math_pkg::FIELD_STRIDE +: 3];
               next_st.cfg.comb[s] =
                  d[logic_math_pkg::SEL_COMB_POS + s*logic_math_pkg::FIELD_STRIDE +: 3];
            end
         end else if (a >= logic_math_pkg::ADDR_COND_BASE &&
                      a <= logic_math_pkg::ADDR_COND_LAST && a[1:0] == 2'b00) begin
            idx = 4'((a - logic_math_pkg::ADDR_COND_BASE) >> 2);
            next_st.cfg.arg_a[idx]   = d[logic_math_pkg::COND_A_POS +: 4];
            next_st.cfg.arg_b[idx]   = d[logic_math_pkg::COND_B_POS +: 4];
            next_st.cfg.cond_op[idx] = d[logic_math_pkg::COND_OP_POS +: 3];
         end else if (a == logic_math_pkg::ADDR_MATH_CTRL) begin
            next_st.cfg.first_src = d[logic_math_pkg::MATH_A_POS +: 3];
            for (int g = 0; g < logic_math_pkg::NUM_STAGE; g++) begin
               next_st.cfg.stage_op[g] =
                  d[logic_math_pkg::MATH_OP_POS + g*logic_math_pkg::FIELD_STRIDE +: 4];
               next_st.cfg.stage_b[g] =
                  d[logic_math_pkg::MATH_B_POS + g*logic_math_pkg::MATH_B_STRIDE +: 3];
            end
         end else if (a >= logic_math_pkg::ADDR_MIN_BASE &&
                      a <= logic_math_pkg::ADDR_MIN_LAST && a[1:0] == 2'b00) begin
            idx = 4'((a - logic_math_pkg::ADDR_MIN_BASE) >> 2);
            next_st.cfg.in_src[idx]    = d[logic_math_pkg::IN_SRC_POS +: 4];
            next_st.cfg.in_weight[idx] = d[logic_math_pkg::HALF_POS +: 16];
         end else if (a >= logic_math_pkg::ADDR_RNG_BASE &&
                      a <= logic_math_pkg::ADDR_RNG_LAST && a[1:0] == 2'b00) begin
            idx = 4'((a - logic_math_pkg::ADDR_RNG_BASE) >> 2);
            next_st.cfg.in_min[idx] = d[15:0];
            next_st.cfg.in_max[idx] = d[logic_math_pkg::HALF_POS +: 16];
         end else if (a == logic_math_pkg::ADDR_OUT_RANGE) begin
            next_st.cfg.out_min = d[15:0];
            next_st.cfg.out_max = d[logic_math_pkg::HALF_POS +: 16];
         end
      end

      if (req.rd) begin
         if (a == logic_math_pkg::ADDR_SEL_CTRL) begin
            next_st.rdata[logic_math_pkg::SEL_EN_POS] = st.cfg.sel_en;
            for (int s = 0; s < logic_math_pkg::NUM_SLOT; s++) begin
               next_st.rdata[logic_math_pkg::SEL_REF_POS
                             + s*logic_math_pkg::FIELD_STRIDE +: 3] = st.cfg.table_ref[s];
               next_st.rdata[logic_math_pkg::SEL_COMB_POS
                             + s*logic_math_pkg::FIELD_STRIDE +: 3] = st.cfg.comb[s];
            end
         end else if (a >= logic_math_pkg::ADDR_COND_BASE &&
                      a <= logic_math_pkg::ADDR_COND_LAST && a[1:0] == 2'b00) begin
            idx = 4'((a - logic_math_pkg::ADDR_COND_BASE) >> 2);
            next_st.rdata[logic_math_pkg::COND_A_POS +: 4]  = st.cfg.arg_a[idx];
            next_st.rdata[logic_math_pkg::COND_B_POS +: 4]  = st.cfg.arg_b[idx];
            next_st.rdata[logic_math_pkg::COND_OP_POS +: 3] = st.cfg.cond_op[idx];
         end else if (a == logic_math_pkg::ADDR_MATH_CTRL) begin
            next_st.rdata[logic_math_pkg::MATH_A_POS +: 3] = st.cfg.first_src;
            for (int g = 0; g < logic_math_pkg::NUM_STAGE; g++) begin
               next_st.rdata[logic_math_pkg::MATH_OP_POS
                             + g*logic_math_pkg::FIELD_STRIDE +: 4] = st.cfg.stage_op[g];
               next_st.rdata[logic_math_pkg::MATH_B_POS
                             + g*logic_math_pkg::MATH_B_STRIDE +: 3] = st.cfg.stage_b[g];
            end
         end else if (a >= logic_math_pkg::ADDR_MIN_BASE &&
                      a <= logic_math_pkg::ADDR_MIN_LAST && a[1:0] == 2'b00) begin
            idx = 4'((a - logic_math_pkg::ADDR_MIN_BASE) >> 2);
            next_st.rdata = {st.cfg.in_weight[idx], 12'h000, st.cfg.in_src[idx]};
         end else if (a >= logic_math_pkg::ADDR_RNG_BASE &&
                      a <= logic_math_pkg::ADDR_RNG_LAST && a[1:0] == 2'b00) begin
            idx = 4'((a - logic_math_pkg::ADDR_RNG_BASE) >> 2);
            next_st.rdata = {st.cfg.in_max[idx], st.cfg.in_min[idx]};
         end else if (a == logic_math_pkg::ADDR_OUT_RANGE) begin
            next_st.rdata = {st.cfg.out_max, st.cfg.out_min};
         end else if (a == logic_math_pkg::ADDR_SEL_STAT) begin
            next_st.rdata = {14'h0000, st.sel_slot, st.sel_value};
         end else if (a == logic_math_pkg::ADDR_MATH_STAT) begin
            next_st.rdata = {st.math_pct, st.math_value};
         end
      end

      // results follow inputs with one register stage
      if (st.cfg.sel_en) begin
         next_st.sel_value = sel_calc;
         next_st.sel_slot  = win_slot;
      end else begin
         next_st.sel_value = 16'h0000;
         next_st.sel_slot  = 2'h0;
      end
      next_st.math_pct   = chain[logic_math_pkg::NUM_STAGE][15:0];
      next_st.math_value = out_calc[15:0];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
         st.cfg.sel_en <= 1'b0;
         for (int i = 0; i < logic_math_pkg::NUM_MIN; i++) begin
            st.cfg.in_weight[i] <= logic_math_pkg::WEIGHT_ONE;
            st.cfg.in_min[i]    <= logic_math_pkg::RST_MIN;
            st.cfg.in_max[i]    <= logic_math_pkg::RST_MAX;
         end
         st.cfg.out_min <= logic_math_pkg::RST_MIN;
         st.cfg.out_max <= logic_math_pkg::RST_MAX;
      end else begin
         st <= next_st;
      end
   end

   assign rdata      = st.rdata;
   assign sel_value  = st.sel_value;
   assign sel_slot   = st.sel_slot;
   assign math_value = st.math_value;

endmodule

// File: design/logic_math_pkg.sv
/*
 * Constants, register map and carrier types for the conditional table
 * selector and the math chain.
 * Assumes one 40 MHz clock and a plain register port with 32-bit data.
 */
package logic_math_pkg;

   // register byte offsets
   localparam logic [7:0] ADDR_SEL_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_COND_BASE = 8'h04;  // nine words, slot*3+condition
   localparam logic [7:0] ADDR_COND_LAST = 8'h24;
   localparam logic [7:0] ADDR_MATH_CTRL = 8'h28;
   localparam logic [7:0] ADDR_MIN_BASE  = 8'h2C;  // five words: source, weight
   localparam logic [7:0] ADDR_MIN_LAST  = 8'h3C;
   localparam logic [7:0] ADDR_RNG_BASE  = 8'h40;  // five words: input min, max
   localparam logic [7:0] ADDR_RNG_LAST  = 8'h50;
   localparam logic [7:0] ADDR_OUT_RANGE = 8'h54;
   localparam logic [7:0] ADDR_SEL_STAT  = 8'h58;
   localparam logic [7:0] ADDR_MATH_STAT = 8'h5C;

   // selector control fields
   localparam int SEL_EN_POS   = 0;
   localparam int SEL_REF_POS  = 4;   // 3 bits each, stride 4
   localparam int SEL_COMB_POS = 16;  // 3 bits each, stride 4
   localparam int FIELD_STRIDE = 4;
   // condition word fields
   localparam int COND_A_POS  = 0;
   localparam int COND_B_POS  = 4;
   localparam int COND_OP_POS = 8;
   // math control fields
   localparam int MATH_A_POS   = 0;
   localparam int MATH_OP_POS  = 4;   // 4 bits each, stride 4
   localparam int MATH_B_POS   = 20;  // 3 bits each, stride 3
   localparam int MATH_B_STRIDE = 3;
   // input word fields
   localparam int IN_SRC_POS = 0;
   localparam int HALF_POS   = 16;

   // fixed-point scales
   localparam logic signed [31:0] PCT_FULL   = 32'sh0000_2710;  // 100.00 %
   localparam logic signed [31:0] PCT_ONE    = 32'sh0000_0064;  // 1.00 %
   localparam logic signed [15:0] WEIGHT_ONE = 16'sh4000;       // 1.0 in Q1.14
   localparam int                 WEIGHT_FRAC = 14;

   // reset values
   localparam logic signed [15:0] RST_MIN = 16'sh0000;
   localparam logic signed [15:0] RST_MAX = 16'sh2710;

   localparam int NUM_SIG   = 8;
   localparam int NUM_TABLE = 8;
   localparam int NUM_SLOT  = 3;
   localparam int NUM_COND  = 9;
   localparam int NUM_MIN   = 5;
   localparam int NUM_STAGE = 4;

   typedef struct packed {
      logic [NUM_SIG-1:0][15:0] value;     // two's complement signals
   } sig_bus_t;

   typedef struct packed {
      logic [NUM_TABLE-1:0][15:0] value;   // lookup table outputs
   } table_bus_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef struct packed {
      logic                         sel_en;
      logic [NUM_SLOT-1:0][2:0]     table_ref;
      logic [NUM_SLOT-1:0][2:0]     comb;
      logic [NUM_COND-1:0][3:0]     arg_a;
      logic [NUM_COND-1:0][3:0]     arg_b;
      logic [NUM_COND-1:0][2:0]     cond_op;
      logic [2:0]                   first_src;
      logic [NUM_STAGE-1:0][3:0]    stage_op;
      logic [NUM_STAGE-1:0][2:0]    stage_b;
      logic [NUM_MIN-1:0][3:0]      in_src;
      logic [NUM_MIN-1:0][15:0]     in_weight;
      logic [NUM_MIN-1:0][15:0]     in_min;
      logic [NUM_MIN-1:0][15:0]     in_max;
      logic [15:0]                  out_min;
      logic [15:0]                  out_max;
   } cfg_t;

   typedef struct packed {
      cfg_t        cfg;
      logic [15:0] sel_value;
      logic [1:0]  sel_slot;
      logic [15:0] math_value;
      logic [15:0] math_pct;
      logic [31:0] rdata;
   } state_t;

endpackage
